// ===== design/jtg_pkg.sv
// Constants, cell layout and state codes of the boundary-scan test port
// Operation
// - Port has clock, select, data in/out, reset
// - Instruction register is exactly two bits
// - Instruction bits shift only in Shift-IR
// - Instruction picks data register and serial path
// - Two data registers: boundary and bypass
// - Code 00 drives pins from boundary register
// - Codes 01 and 10 mean sample/preload
// - Sample/preload leaves core and pins untouched
// - Code 11 bypasses, normal function continues
// - Test reset loads the bypass code
// - 144 cells, cell 144 shifts out first
// - Tristate cells enable outputs when high
// - All-zero chain makes every output float
// - Bidir: input, output, tristate; output: output, tristate
// - Input pins have one capture cell only
package jtg_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int IR_WIDTH   = 2;
	localparam int BSR_CELLS  = 144;
	localparam int PIN_COUNT  = 61;

	// ****************************************
	// Instruction codes
	// ****************************************
	localparam logic [IR_WIDTH-1:0] IR_EXTEST   = 2'h0;
	localparam logic [IR_WIDTH-1:0] IR_SAMPLE_A = 2'h1;
	localparam logic [IR_WIDTH-1:0] IR_SAMPLE_B = 2'h2;
	localparam logic [IR_WIDTH-1:0] IR_BYPASS   = 2'h3;
	localparam logic [IR_WIDTH-1:0] IR_CAPTURE  = 2'h1;   // Fixed pattern seen in Capture-IR

	// Synchroniser reset levels {trstN, tdi, tms, tck}
	localparam logic [3:0] SYNC_RESET = 4'he;
	localparam int SYNC_TCK  = 0;
	localparam int SYNC_TMS  = 1;
	localparam int SYNC_TDI  = 2;
	localparam int SYNC_TRST = 3;

	// ****************************************
	// Pin kinds in chain order
	// ****************************************
	typedef enum logic [1:0] {
		PIN_BIDIR  = 2'b00,
		PIN_INPUT  = 2'b01,
		PIN_OUTPUT = 2'b10
	} jtg_pin_t;

	// Chain order from cell 1: 20 bidir, 10 inputs, 3 outputs, 8 bidir, 16 outputs, 4 bidir
	function automatic jtg_pin_t pinKind(input int p);
		if (p < 20) return PIN_BIDIR;
		else if (p < 30) return PIN_INPUT;
		else if (p < 33) return PIN_OUTPUT;
		else if (p < 41) return PIN_BIDIR;
		else if (p < 57) return PIN_OUTPUT;
		else return PIN_BIDIR;
	endfunction : pinKind

	function automatic int pinCells(input int p);
		return (pinKind(p) == PIN_BIDIR) ? 3 : (pinKind(p) == PIN_INPUT) ? 1 : 2;
	endfunction : pinCells

	// Zero-based index of the first cell of a pin
	function automatic int pinBase(input int p);
		int sum;
		sum = 0;
		for (int q = 0; q < p; q++) begin
			sum += pinCells(q);
		end
		return sum;
	endfunction : pinBase

	// ****************************************
	// Controller states
	// ****************************************
	typedef enum logic [3:0] {
		ST_RESET      = 4'b0000,
		ST_IDLE       = 4'b0001,
		ST_SEL_DR     = 4'b0010,
		ST_CAPTURE_DR = 4'b0011,
		ST_SHIFT_DR   = 4'b0100,
		ST_EXIT1_DR   = 4'b0101,
		ST_PAUSE_DR   = 4'b0110,
		ST_EXIT2_DR   = 4'b0111,
		ST_UPDATE_DR  = 4'b1000,
		ST_SEL_IR     = 4'b1001,
		ST_CAPTURE_IR = 4'b1010,
		ST_SHIFT_IR   = 4'b1011,
		ST_EXIT1_IR   = 4'b1100,
		ST_PAUSE_IR   = 4'b1101,
		ST_EXIT2_IR   = 4'b1110,
		ST_UPDATE_IR  = 4'b1111
	} jtg_state_t;

endpackage : jtg_pkg

// ===== design/jtg_edge_if.sv
// Synchronised test port levels and clock edges
`timescale 1ns/1ps
interface jtg_edge_if;
	logic tckRise;
	logic tckFall;
	logic tmsLevel;
	logic tdiLevel;
	logic trstN;

	modport src (output tckRise, output tckFall, output tmsLevel, output tdiLevel, output trstN);
	modport dst (input tckRise, input tckFall, input tmsLevel, input tdiLevel, input trstN);
endinterface : jtg_edge_if

// ===== design/jtg_pin_sync.sv
// Three-stage synchronisers and edge finder for the test port pins
`timescale 1ns/1ps
module jtg_pin_sync (
	input  wire logic core_clk,
	input  wire logic reset_n,
	input  wire logic tck,
	input  wire logic tms,
	input  wire logic tdi,
	input  wire logic trstN,
	jtg_edge_if.src   edges
);
	import jtg_pkg::*;

	logic [3:0] rawPins;
	logic [3:0] stage1;
	logic [3:0] stage2;
	logic [3:0] stage3;
	logic [3:0] stable;
	logic [3:0] agree;
	logic       tckRise;
	logic       tckFall;

	assign rawPins = {trstN, tdi, tms, tck};

	// Stage 1 feeds stage 2 only; a level counts once stages 2 and 3 agree
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_sync
			assign agree[i] = (stage2[i] == stage3[i]);
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					stage1[i] <= SYNC_RESET[i];
					stage2[i] <= SYNC_RESET[i];
					stage3[i] <= SYNC_RESET[i];
					stable[i] <= SYNC_RESET[i];
				end else begin
					stage1[i] <= rawPins[i];
					stage2[i] <= stage1[i];
					stage3[i] <= stage2[i];
					stable[i] <= agree[i] ? stage3[i] : stable[i];
				end
			end
		end
	endgenerate

	// One-cycle edge pulses of the test clock
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tckRise <= 1'b0;
			tckFall <= 1'b0;
		end else begin
			tckRise <= agree[SYNC_TCK] && stage3[SYNC_TCK] && !stable[SYNC_TCK];
			tckFall <= agree[SYNC_TCK] && !stage3[SYNC_TCK] && stable[SYNC_TCK];
		end
	end

	assign edges.tckRise  = tckRise;
	assign edges.tckFall  = tckFall;
	assign edges.tmsLevel = stable[SYNC_TMS];
	assign edges.tdiLevel = stable[SYNC_TDI];
	assign edges.trstN    = stable[SYNC_TRST];

endmodule : jtg_pin_sync

// ===== design/jtg_tap.sv
// Boundary-scan test access port: controller, instruction, bypass and boundary chain
`timescale 1ns/1ps
module jtg_tap (
	input  wire logic                           core_clk,
	input  wire logic                           reset_n,
	input  wire logic                           tck,
	input  wire logic                           tms,
	input  wire logic                           tdi,
	input  wire logic                           trstN,
	output logic                                tdo,
	output logic                                tdoOe,
	output logic                                testMode,
	input  wire logic [jtg_pkg::PIN_COUNT-1:0]  coreOut,
	input  wire logic [jtg_pkg::PIN_COUNT-1:0]  coreOe,
	input  wire logic [jtg_pkg::PIN_COUNT-1:0]  padIn,
	output logic      [jtg_pkg::PIN_COUNT-1:0]  padOut,
	output logic      [jtg_pkg::PIN_COUNT-1:0]  padOe
);
	import jtg_pkg::*;

	jtg_edge_if edges ();

	jtg_state_t              state;
	jtg_state_t              next_state;
	logic [IR_WIDTH-1:0]     irShift;
	logic [IR_WIDTH-1:0]     instr;
	logic                    bypass;
	logic [BSR_CELLS-1:0]    chain;
	logic [BSR_CELLS-1:0]    updReg;
	logic [BSR_CELLS-1:0]    captureVec;
	logic [PIN_COUNT-1:0]    padMeta;
	logic [PIN_COUNT-1:0]    padMid;
	logic [PIN_COUNT-1:0]    padSync;
	logic [PIN_COUNT-1:0]    padHeld;
	logic [PIN_COUNT-1:0]    extOut;
	logic [PIN_COUNT-1:0]    extOe;
	logic [PIN_COUNT-1:0]    normOut;
	logic [PIN_COUNT-1:0]    normOe;
	logic [PIN_COUNT-1:0]    next_padOut;
	logic [PIN_COUNT-1:0]    next_padOe;

	// ****************************************
	// Pin synchroniser
	// ****************************************
	jtg_pin_sync u_sync (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.tck      (tck),
		.tms      (tms),
		.tdi      (tdi),
		.trstN    (trstN),
		.edges    (edges.src)
	);

	// ****************************************
	// Controller
	// ****************************************

	always_comb begin
		next_state = state;
		unique case (state)
			ST_RESET:      next_state = edges.tmsLevel ? ST_RESET : ST_IDLE;
			ST_IDLE:       next_state = edges.tmsLevel ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR:     next_state = edges.tmsLevel ? ST_SEL_IR : ST_CAPTURE_DR;
			ST_CAPTURE_DR: next_state = edges.tmsLevel ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR:   next_state = edges.tmsLevel ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR:   next_state = edges.tmsLevel ? ST_UPDATE_DR : ST_PAUSE_DR;
			ST_PAUSE_DR:   next_state = edges.tmsLevel ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR:   next_state = edges.tmsLevel ? ST_UPDATE_DR : ST_SHIFT_DR;
			ST_UPDATE_DR:  next_state = edges.tmsLevel ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR:     next_state = edges.tmsLevel ? ST_RESET : ST_CAPTURE_IR;
			ST_CAPTURE_IR: next_state = edges.tmsLevel ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR:   next_state = edges.tmsLevel ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR:   next_state = edges.tmsLevel ? ST_UPDATE_IR : ST_PAUSE_IR;
			ST_PAUSE_IR:   next_state = edges.tmsLevel ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR:   next_state = edges.tmsLevel ? ST_UPDATE_IR : ST_SHIFT_IR;
			ST_UPDATE_IR:  next_state = edges.tmsLevel ? ST_SEL_DR : ST_IDLE;
		endcase
	end

	// reset by pin, step on rise
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_RESET;
		end else if (!edges.trstN) begin
			state <= ST_RESET;
		end else if (edges.tckRise) begin
			state <= next_state;
		end
	end

	// Decoded controller steps, each a one-cycle strobe on a test clock rise
	wire stepCaptureIr = edges.tckRise && (state == ST_CAPTURE_IR);
	wire stepShiftIr   = edges.tckRise && (state == ST_SHIFT_IR);
	wire stepUpdateIr  = edges.tckRise && (state == ST_UPDATE_IR);
	wire stepCaptureDr = edges.tckRise && (state == ST_CAPTURE_DR);
	wire stepShiftDr   = edges.tckRise && (state == ST_SHIFT_DR);
	wire stepUpdateDr  = edges.tckRise && (state == ST_UPDATE_DR);

	// ****************************************
	// Instruction register
	// ****************************************

	wire selBsr   = (instr != IR_BYPASS);
	// only code 00 takes the pins
	wire extestOn = (instr == IR_EXTEST);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			irShift <= IR_BYPASS;
		end else if (stepCaptureIr) begin
			irShift <= IR_CAPTURE;
		end else if (stepShiftIr) begin
			irShift <= {edges.tdiLevel, irShift[IR_WIDTH-1:1]};
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			instr <= IR_BYPASS;
		end else if (state == ST_RESET) begin
			instr <= IR_BYPASS;
		end else if (stepUpdateIr) begin
			instr <= irShift;   // two bits taken whole
		end
	end

	// ****************************************
	// Bypass register
	// ****************************************

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			bypass <= 1'b0;
		end else if (stepCaptureDr && !selBsr) begin
			bypass <= 1'b0;
		end else if (stepShiftDr && !selBsr) begin
			bypass <= edges.tdiLevel;
		end
	end

	// ****************************************
	// Boundary chain
	// ****************************************

	// Pin inputs cross into the core clock; a level counts once stages 2 and 3 agree
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			padMeta <= '0;
			padMid  <= '0;
			padSync <= '0;
			padHeld <= '0;
		end else begin
			padMeta <= padIn;
			padMid  <= padMeta;
			padSync <= padMid;
			padHeld <= (padMid & padSync) | (padHeld & (padMid | padSync));
		end
	end

	// Per-pin cell wiring; input pins have no drive side
	genvar p;
	generate
		for (p = 0; p < PIN_COUNT; p++) begin : g_pin
			localparam int BASE = pinBase(p);
			if (pinKind(p) == PIN_INPUT) begin : g_in
				assign captureVec[BASE] = padHeld[p];
				assign extOut[p]  = 1'b0;
				assign extOe[p]   = 1'b0;
				assign normOut[p] = 1'b0;
				assign normOe[p]  = 1'b0;
			end else if (pinKind(p) == PIN_OUTPUT) begin : g_out
				assign captureVec[BASE]   = coreOut[p];
				assign captureVec[BASE+1] = coreOe[p];
				assign extOut[p]  = updReg[BASE];
				assign extOe[p]   = updReg[BASE+1];
				assign normOut[p] = coreOut[p];
				assign normOe[p]  = coreOe[p];
			end else begin : g_bidir
				assign captureVec[BASE]   = padHeld[p];
				assign captureVec[BASE+1] = coreOut[p];
				assign captureVec[BASE+2] = coreOe[p];
				assign extOut[p]  = updReg[BASE+1];
				assign extOe[p]   = updReg[BASE+2];
				assign normOut[p] = coreOut[p];
				assign normOe[p]  = coreOe[p];
			end
		end
	endgenerate

	// cell 1 takes data in, cell 144 leaves first
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			chain <= '0;
		end else if (stepCaptureDr && selBsr) begin
			chain <= captureVec;
		end else if (stepShiftDr && selBsr) begin
			chain <= {chain[BSR_CELLS-2:0], edges.tdiLevel};
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			updReg <= '0;
		end else if (stepUpdateDr && selBsr) begin
			updReg <= chain;
		end
	end

	// ****************************************
	// Pin drive
	// ****************************************

	// test drives pins; zero enables float; else core passes
	assign next_padOut = extestOn ? extOut : normOut;
	assign next_padOe  = extestOn ? extOe  : normOe;

	// Registered drive costs one core cycle but keeps pins glitch-free
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			padOut   <= '0;
			padOe    <= '0;
			testMode <= 1'b0;
		end else begin
			padOut   <= next_padOut;
			padOe    <= next_padOe;
			testMode <= extestOn;
		end
	end

	// ****************************************
	// Test data output
	// ****************************************

	wire serialOut = (state == ST_SHIFT_IR) ? irShift[0] : (selBsr ? chain[BSR_CELLS-1] : bypass);
	wire shifting  = (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tdo   <= 1'b0;
			tdoOe <= 1'b0;
		end else if (edges.tckFall) begin
			tdo   <= shifting ? serialOut : 1'b0;
			tdoOe <= shifting;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	tap_reset_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		!edges.trstN |=> state == ST_RESET)
		else $error("Controller left reset while test reset low");

	ir_bypass_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		state == ST_RESET |=> instr == IR_BYPASS)
		else $error("Bypass code not loaded in reset state");

	ir_hold_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		!(stepShiftIr || stepCaptureIr) |=> irShift == $past(irShift))
		else $error("Instruction shifter moved outside Shift-IR");

	sample_decode_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		(instr == IR_SAMPLE_A || instr == IR_SAMPLE_B) |-> selBsr && !extestOn)
		else $error("Sample code decoded wrongly");

	bypass_path_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		stepShiftDr && !selBsr |=> bypass == $past(edges.tdiLevel) && chain == $past(chain))
		else $error("Bypass stage did not take data in");

	core_pass_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		!extestOn |=> padOut == $past(normOut) && padOe == $past(normOe))
		else $error("Scan logic disturbed normal pin drive");

	extest_pins_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		extestOn |=> padOut == $past(extOut) && testMode)
		else $error("Pins not driven from boundary latch");

	zero_float_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		extestOn && updReg == '0 |=> padOe == '0)
		else $error("All-zero latch left a pin driven");

	tdo_first_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		edges.tckFall && state == ST_SHIFT_DR && selBsr |=> tdo == $past(chain[BSR_CELLS-1]) && tdoOe)
		else $error("Last chain cell not on test output");

	tdo_fall_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		!edges.tckFall |=> $stable(tdo) && $stable(tdoOe))
		else $error("Test output changed away from falling edge");

endmodule : jtg_tap

// ===== testbench/jtg_scan_master.sv
// Behavioural boundary-scan controller that drives the test port pins
`timescale 1ns/1ps
module jtg_scan_master (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	output logic      trstN,
	input  wire logic tdo
);

	// ****************************************
	// Idle levels
	// ****************************************
	// all port pins
	initial begin
		tck   = 1'b0;
		tms   = 1'b1;
		tdi   = 1'b0;
		trstN = 1'b1;
	end

	// One test clock; reply taken before the fall, as the device answers slowly
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#400;
		tck = 1'b1;
		#400;
		q   = tdo;
		tck = 1'b0;
	endtask : step

	// Full scan from Idle back to Idle; clock stands still afterwards
	task automatic scan(input logic isIr, input int n, input logic [143:0] din, output logic [143:0] dout);
		logic q;
		dout = '0;
		step(1'b1, ~tdi, q);
		if (isIr) begin
			step(1'b1, ~tdi, q);
		end
		step(1'b0, ~tdi, q);
		step(1'b0, ~tdi, q);
		for (int j = 0; j < n; j++) begin
			step((j == n - 1), din[j], q);
			dout[j] = q;
		end
		step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
		tdi = ~tdi;   // Released line shows no stale value
	endtask : scan

	task automatic toReset();
		logic q;
		repeat (5) step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
	endtask : toReset

	task automatic pulseReset();
		logic q;
		trstN = 1'b0;
		#1000;
		trstN = 1'b1;
		#1000;
		step(1'b0, ~tdi, q);   // Leave reset for Idle, as every scan starts there
	endtask : pulseReset

endmodule : jtg_scan_master

// ===== testbench/boundary_scan_tap_tb_top.sv
// Self-checking bench of the boundary-scan test port
`timescale 1ns/1ps
module boundary_scan_tap_tb_top;
	import jtg_pkg::*;

	logic                 core_clk;
	logic                 reset_n;
	logic                 tck;
	logic                 tms;
	logic                 tdi;
	logic                 trstN;
	logic                 tdo;
	logic                 tdoOe;
	logic                 testMode;
	logic [PIN_COUNT-1:0] coreOut;
	logic [PIN_COUNT-1:0] coreOe;
	logic [PIN_COUNT-1:0] padIn;
	logic [PIN_COUNT-1:0] padOut;
	logic [PIN_COUNT-1:0] padOe;
	logic [143:0]         latch;
	int                   inIdx[PIN_COUNT];
	int                   outIdx[PIN_COUNT];
	int                   enIdx[PIN_COUNT];
	int                   fails;
	int                   cmp_count;

	jtg_tap DUT (.core_clk(core_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN),
		.tdo(tdo), .tdoOe(tdoOe), .testMode(testMode), .coreOut(coreOut), .coreOe(coreOe), .padIn(padIn),
		.padOut(padOut), .padOe(padOe));
	jtg_scan_master ctl (.tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN), .tdo(tdo));

	// Clock
	initial core_clk = 1'b0;
	always #50 core_clk = ~core_clk;

	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input string what, input logic [143:0] exp, input logic [143:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wrap_up();
		$display("Comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up

	// Own cell map: kinds 0 bidir, 1 input, 2 output
	task automatic buildLayout();
		int segKind[6] = '{0, 1, 2, 0, 2, 0};
		int segLen[6]  = '{20, 10, 3, 8, 16, 4};
		int p = 0;
		int c = 0;
		for (int s = 0; s < 6; s++) begin
			for (int k = 0; k < segLen[s]; k++) begin
				inIdx[p]  = (segKind[s] == 2) ? -1 : c;
				c         = c + ((segKind[s] == 2) ? 0 : 1);
				outIdx[p] = (segKind[s] == 1) ? -1 : c;
				enIdx[p]  = (segKind[s] == 1) ? -1 : c + 1;
				c         = c + ((segKind[s] == 1) ? 0 : 2);
				p++;
			end
		end
	endtask : buildLayout

	function automatic logic [143:0] capture();
		logic [143:0] v = '0;
		for (int p = 0; p < PIN_COUNT; p++) begin
			if (inIdx[p] >= 0) v[inIdx[p]] = padIn[p];
			if (outIdx[p] >= 0) begin
				v[outIdx[p]] = coreOut[p];
				v[enIdx[p]]  = coreOe[p];
			end
		end
		return v;
	endfunction : capture

	// Pads come from core, or from the latch in pin test mode
	task automatic checkPads(input logic ext);
		logic [PIN_COUNT-1:0] eo;
		logic [PIN_COUNT-1:0] ee;
		for (int p = 0; p < PIN_COUNT; p++) begin
			eo[p] = (outIdx[p] < 0) ? 1'b0 : ext ? latch[outIdx[p]] : coreOut[p];
			ee[p] = (outIdx[p] < 0) ? 1'b0 : ext ? latch[enIdx[p]] : coreOe[p];
		end
		check("padOut", 144'(eo), 144'(padOut));
		check("padOe", 144'(ee), 144'(padOe));
		check("testMode", {143'h0, ext}, {143'h0, testMode});
	endtask : checkPads

	task automatic setCore(input logic [PIN_COUNT-1:0] o, input logic [PIN_COUNT-1:0] e,
		input logic [PIN_COUNT-1:0] i);
		@(posedge core_clk);
		#1;
		coreOut = o;
		coreOe  = e;
		padIn   = i;
		repeat (6) @(posedge core_clk);
		#1;
	endtask : setCore

	// Cell 144 leaves first, tdi enters cell 1
	task automatic drCells(input logic [143:0] cin, output logic [143:0] cout);
		logic [143:0] din;
		logic [143:0] dout;
		for (int j = 0; j < 144; j++) din[j] = cin[143 - j];
		ctl.scan(1'b0, 144, din, dout);
		for (int j = 0; j < 144; j++) cout[j] = dout[143 - j];
	endtask : drCells

	task automatic loadIr(input logic [1:0] code);
		logic [143:0] dout;
		ctl.scan(1'b1, 2, {142'h0, code}, dout);
		check("irCapture", 144'h01, {142'h0, dout[1:0]});
		repeat (3) @(posedge core_clk);
		#1;
	endtask : loadIr

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic testBypass();
		logic [143:0] dout;
		ctl.scan(1'b0, 8, 144'h00b2, dout);
		check("bypassOut", 144'h0064, {136'h0, dout[7:0]});
		checkPads(1'b0);
		repeat (6) @(posedge core_clk);
		#1;
		check("tdoIdle", 144'h0, {142'h0, tdo, tdoOe});
	endtask : testBypass

	task automatic testSample(input logic [1:0] code, input logic [143:0] pre, input logic [PIN_COUNT-1:0] o);
		logic [143:0] got;
		setCore(o, ~o ^ 61'h00f0_3c3c_a5a5_0ff0, o ^ 61'h1555_aaaa_3333_cccc);
		loadIr(code);
		drCells(pre, got);
		check("sampleCells", capture(), got);
		latch = pre;
		repeat (3) @(posedge core_clk);
		#1;
		checkPads(1'b0);
	endtask : testSample

	task automatic testExtest();
		logic [143:0] got;
		loadIr(IR_EXTEST);
		checkPads(1'b1);
		setCore(~coreOut, ~coreOe, padIn);
		checkPads(1'b1);
		drCells(144'h0, got);
		check("extestCells", capture(), got);
		latch = '0;
		repeat (3) @(posedge core_clk);
		#1;
		checkPads(1'b1);
	endtask : testExtest

	task automatic testResets();
		ctl.toReset();
		repeat (3) @(posedge core_clk);
		#1;
		checkPads(1'b0);
		loadIr(IR_EXTEST);
		ctl.pulseReset();
		repeat (3) @(posedge core_clk);
		#1;
		checkPads(1'b0);
		testBypass();
	endtask : testResets

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		fails     = 0;
		cmp_count = 0;
		reset_n   = 1'b0;
		coreOut   = '0;
		coreOe    = '0;
		padIn     = '0;
		latch     = '0;
		buildLayout();
		repeat (12) @(posedge core_clk);
		#1;
		reset_n = 1'b1;
		setCore(61'h1a5a_c3c3_0f0f_3cc3, 61'h0f0f_9696_6969_a55a, 61'h1333_cccc_5555_aaaa);
		ctl.toReset();
		testBypass();
		testSample(IR_SAMPLE_A, {9{16'ha5c3}}, 61'h0234_5678_9abc_def0);
		// Preload the pin image before the pin test
		testSample(IR_SAMPLE_B, {9{16'h6f19}}, 61'h1edc_ba98_7654_3210);
		testExtest();
		testResets();
		wrap_up();
	end

	// Watchdog well beyond the expected run
	initial begin
		#2000000;
		fails++;
		$display("ERROR watchdog expected finish seen timeout");
		wrap_up();
	end

endmodule : boundary_scan_tap_tb_top
